// ===== core/wvr_defs.vh
`ifndef WVR_DEFS_VH
`define WVR_DEFS_VH
// clock rate in kHz
`define WVR_CLK_KHZ 10000
// watchdog timeouts in microseconds
`define WVR_TMO_MIN_US 531000
`define WVR_TMO_MAX_US 578000
`define WVR_TMO_STEP_US 15600
// longest sequence duration in microseconds
`define WVR_SEQ_MAX_US 250000
// cycles derived from the times above (longest times round down)
`define WVR_TMO_MIN_CYC ((`WVR_TMO_MIN_US / 1000) * `WVR_CLK_KHZ)
`define WVR_TMO_STEP_CYC ((`WVR_TMO_STEP_US * (`WVR_CLK_KHZ / 1000)))
`define WVR_SEQ_MAX_CYC ((`WVR_SEQ_MAX_US / 1000) * `WVR_CLK_KHZ)
// cycles per sequence command step; 15 steps stay far below the limit
`define WVR_STEP_CYC 1000
// number of monitor units and command outputs
`define WVR_NUM_MON 4
`define WVR_CMD_W 15
// command word bit positions
`define WVR_B_PM_DMS_A 0
`define WVR_B_PM_DMS_B 1
`define WVR_B_PM_ATT_A 2
`define WVR_B_PM_ATT_B 3
`define WVR_B_TU_A 4
`define WVR_B_TU_B 5
`define WVR_B_LCB 6
`define WVR_B_BUS_SEL 7
`define WVR_B_PM_PWR 11
`define WVR_PTR_W 4
`define WVR_PTR_RST 4'h0
`endif

// ===== core/wvr_sequencer.v
// Overview of operation
// - each monitor watchdog has distinct spaced timeout
// - expired watchdog raises a reconfiguration request
// - successive requests alternate sequencer A and B
// - start needs requests from two monitors
// - hold subsystem reset during reconfiguration
// - read stored command sequence anew, issue in order
// - finish under 250 ms, then release all
// - repeated expiry is served by other sequencer
// - stuck single request never retriggers alone
// - commands switch modules, clocks, bit, bus sides
// - pointer picks stored configuration, increments each time
// - externally forced pointer value is accepted
// - four independent watchdogs each raise requests
`timescale 1ns/1ns
`default_nettype none
`include "wvr_defs.vh"
module wvr_sequencer #(
    parameter integer NUM_MON = `WVR_NUM_MON,
    parameter integer TMO_BASE = `WVR_TMO_MIN_CYC,
    parameter integer TMO_STEP = `WVR_TMO_STEP_CYC,
    parameter integer STEP_CYC = `WVR_STEP_CYC,
    parameter integer PTR_W = `WVR_PTR_W
) (
    input wire clk, // system clock
    input wire rst_n, // system reset, active low
    input wire liveness_pulse, // re-arm from active processor module
    input wire ptr_load, // force the configuration pointer
    input wire [PTR_W-1:0] ptr_value, // forced pointer value
    output reg subsys_reset_n_q, // reset to computing units, active low
    output reg [NUM_MON-1:0] req_a_q, // requests toward sequencer A
    output reg [NUM_MON-1:0] req_b_q, // requests toward sequencer B
    output reg [`WVR_CMD_W-1:0] high_power_command_q, // command levels
    output reg cmd_strobe_q, // one pulse per issued command
    output reg active_seq_b_q, // last sequencer that ran was B
    output reg [PTR_W-1:0] cfg_ptr_q // configuration pointer
);
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_RUN = 3'h2;
    localparam [2:0] ST_DONE = 3'h4;
    localparam integer CNT_W = 24;
    localparam integer NSTEP = `WVR_CMD_W;
    localparam integer STEP_LAST_I = STEP_CYC - 1;
    localparam [CNT_W-1:0] STEP_LAST = STEP_LAST_I[CNT_W-1:0];
    localparam integer NSTEP_LAST_I = NSTEP - 1;
    localparam [3:0] NSTEP_LAST = NSTEP_LAST_I[3:0];

    // stored configurations: each pointer value is a distinct setting
    function [`WVR_CMD_W-1:0] prom_word;
        input [PTR_W-1:0] p;
        reg [`WVR_CMD_W-1:0] w;
        begin
            w = {`WVR_CMD_W{1'b0}};
            w[`WVR_B_PM_DMS_A] = ~p[0];
            w[`WVR_B_PM_DMS_B] = p[0];
            w[`WVR_B_PM_ATT_A] = ~p[1];
            w[`WVR_B_PM_ATT_B] = p[1];
            w[`WVR_B_TU_A] = ~p[2];
            w[`WVR_B_TU_B] = p[2];
            w[`WVR_B_LCB] = p[3];
            w[`WVR_B_BUS_SEL+:4] = {4{p[2]}};
            w[`WVR_B_PM_PWR+:4] = {p[1], ~p[1], p[0], ~p[0]};
            prom_word = w;
        end
    endfunction

    // count of set bits
    function integer ones;
        input [NUM_MON-1:0] v;
        integer i;
        begin
            ones = 0;
            for (i = 0; i < NUM_MON; i = i + 1)
                if (v[i])
                    ones = ones + 1;
        end
    endfunction

    // last count of monitor idx before it expires
    function [CNT_W-1:0] tmo_last;
        input integer idx;
        integer t;
        begin
            t = TMO_BASE + idx * TMO_STEP - 1;
            tmo_last = t[CNT_W-1:0];
        end
    endfunction

    reg [CNT_W-1:0] wd_cnt_q [0:NUM_MON-1];
    reg [NUM_MON-1:0] dir_b_q;
    reg [NUM_MON-1:0] expired_q;
    reg [2:0] st_q [0:1];
    reg [CNT_W-1:0] step_cnt_q [0:1];
    reg [3:0] step_q [0:1];
    reg [`WVR_CMD_W-1:0] word_q [0:1];
    reg [NUM_MON-1:0] seen_q [0:1];
    wire [NUM_MON-1:0] side_req [0:1];
    wire [NUM_MON-1:0] new_req [0:1];
    wire go [0:1];
    wire fin [0:1];
    wire busy;
    integer m;
    integer q;

    assign busy = (st_q[0] != ST_IDLE) || (st_q[1] != ST_IDLE);

    // four spaced watchdogs with alternating requests
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (m = 0; m < NUM_MON; m = m + 1)
                wd_cnt_q[m] <= {CNT_W{1'b0}};
            dir_b_q <= {NUM_MON{1'b0}};
            expired_q <= {NUM_MON{1'b0}};
        end
        else
        begin
            for (m = 0; m < NUM_MON; m = m + 1)
            begin
                if (liveness_pulse || busy)
                    wd_cnt_q[m] <= {CNT_W{1'b0}};
                else if (wd_cnt_q[m] == tmo_last(m))
                    wd_cnt_q[m] <= {CNT_W{1'b0}};
                else
                    wd_cnt_q[m] <= wd_cnt_q[m] + 1'b1;
                if (!busy && !liveness_pulse &&
                    wd_cnt_q[m] == tmo_last(m))
                begin
                    expired_q[m] <= 1'b1;
                    dir_b_q[m] <= ~dir_b_q[m];
                end
                else if (fin[0] || fin[1])
                    expired_q[m] <= 1'b0;
            end
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_a_q <= {NUM_MON{1'b0}};
            req_b_q <= {NUM_MON{1'b0}};
        end
        else
        begin
            // toggled at expiry: a unit's first request goes to A
            req_a_q <= (fin[0] || fin[1]) ? {NUM_MON{1'b0}} :
                       (expired_q & dir_b_q);
            req_b_q <= (fin[0] || fin[1]) ? {NUM_MON{1'b0}} :
                       (expired_q & ~dir_b_q);
        end
    end

    assign side_req[0] = req_a_q;
    assign side_req[1] = req_b_q;
    // only requests not yet consumed count toward a start
    assign new_req[0] = side_req[0] & ~seen_q[0];
    assign new_req[1] = side_req[1] & ~seen_q[1];
    assign go[0] = (st_q[0] == ST_IDLE) && !busy && (ones(new_req[0]) >= 2);
    assign go[1] = (st_q[1] == ST_IDLE) && !busy && !go[0] &&
                   (ones(new_req[1]) >= 2);
    assign fin[0] = (st_q[0] == ST_DONE);
    assign fin[1] = (st_q[1] == ST_DONE);

    // two sequencers, at most one running
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (q = 0; q < 2; q = q + 1)
            begin
                st_q[q] <= ST_IDLE;
                step_cnt_q[q] <= {CNT_W{1'b0}};
                step_q[q] <= 4'h0;
                word_q[q] <= {`WVR_CMD_W{1'b0}};
                seen_q[q] <= {NUM_MON{1'b0}};
            end
        end
        else
        begin
            for (q = 0; q < 2; q = q + 1)
            begin
                // a released request re-arms its vote
                seen_q[q] <= seen_q[q] & side_req[q];
                case (st_q[q])
                    ST_IDLE:
                    begin
                        if (go[q])
                        begin
                            word_q[q] <= prom_word(cfg_ptr_q);
                            seen_q[q] <= new_req[q];
                            step_q[q] <= 4'h0;
                            step_cnt_q[q] <= {CNT_W{1'b0}};
                            st_q[q] <= ST_RUN;
                        end
                    end
                    ST_RUN:
                    begin
                        // bounded steps keep total under limit
                        if (step_cnt_q[q] == STEP_LAST)
                        begin
                            step_cnt_q[q] <= {CNT_W{1'b0}};
                            if (step_q[q] == NSTEP_LAST)
                                st_q[q] <= ST_DONE;
                            else
                                step_q[q] <= step_q[q] + 4'h1;
                        end
                        else
                            step_cnt_q[q] <= step_cnt_q[q] + 1'b1;
                    end
                    ST_DONE:
                        st_q[q] <= ST_IDLE;
                    default:
                        st_q[q] <= ST_IDLE;
                endcase
            end
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            subsys_reset_n_q <= 1'b1;
            high_power_command_q <= {`WVR_CMD_W{1'b0}};
            cmd_strobe_q <= 1'b0;
            active_seq_b_q <= 1'b0;
            cfg_ptr_q <= `WVR_PTR_RST;
        end
        else
        begin
            // reset held from start until completion
            subsys_reset_n_q <= !(go[0] || go[1] ||
                                  (busy && !fin[0] && !fin[1]));
            cmd_strobe_q <= 1'b0;
            // issue one command per step in order
            if (st_q[0] == ST_RUN && step_cnt_q[0] == STEP_LAST)
            begin
                high_power_command_q[step_q[0]] <= word_q[0][step_q[0]];
                cmd_strobe_q <= 1'b1;
            end
            else if (st_q[1] == ST_RUN && step_cnt_q[1] == STEP_LAST)
            begin
                high_power_command_q[step_q[1]] <= word_q[1][step_q[1]];
                cmd_strobe_q <= 1'b1;
            end
            if (go[0])
                active_seq_b_q <= 1'b0;
            else if (go[1])
                active_seq_b_q <= 1'b1;
            // forced pointer wins; else advance per run
            if (ptr_load)
                cfg_ptr_q <= ptr_value;
            else if (fin[0] || fin[1])
                cfg_ptr_q <= cfg_ptr_q + 1'b1;
        end
    end
endmodule // wvr_sequencer
`default_nettype wire

// ===== dv/wvr_seq_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module wvr_seq_monitor #(
    parameter integer TMO_BASE = 50,
    parameter integer STEP_CYC = 4
) (
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic liveness_pulse, // re-arm
    input wire logic ptr_load, // force pointer
    input wire logic [3:0] ptr_value, // forced value
    input wire logic subsys_reset_n_q, // subsystem reset
    input wire logic [3:0] req_a_q, // requests to A
    input wire logic [3:0] req_b_q, // requests to B
    input wire logic cmd_strobe_q, // command pulse
    input wire logic [3:0] cfg_ptr_q // pointer
);
    localparam int RUN_MAX = 16 * STEP_CYC;
    logic [31:0] idle_q;
    logic [15:0] run_q;
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            idle_q <= 32'h00000000;
            run_q <= 16'h0000;
        end
        else
        begin
            // saturate so a long spell without liveness pulses cannot wrap
            idle_q <= liveness_pulse ? 32'h00000000 :
                      (&idle_q ? idle_q : idle_q + 32'h00000001);
            run_q <= subsys_reset_n_q ? 16'h0000 : run_q + 16'h0001;
        end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_req_after_idle: assert property (
        ((req_a_q & ~$past(req_a_q)) | (req_b_q & ~$past(req_b_q))) != 0
        |-> idle_q >= TMO_BASE)
        else $error("request raised before timeout");
    a_start_needs_two: assert property (
        $fell(subsys_reset_n_q) |->
        $countones(req_a_q) >= 2 || $countones(req_b_q) >= 2)
        else $error("run started without two requests");
    a_reset_holds_reqs: assert property (
        !subsys_reset_n_q |-> (req_a_q | req_b_q) != 0)
        else $error("reset low without requests");
    a_strobe_in_run: assert property (
        cmd_strobe_q |-> !$past(subsys_reset_n_q))
        else $error("command outside run");
    a_run_bounded: assert property (
        run_q <= RUN_MAX)
        else $error("run too long");
    a_release_together: assert property (
        $rose(subsys_reset_n_q) |-> req_a_q == 0 && req_b_q == 0)
        else $error("requests left after release");
    a_ptr_steps: assert property (
        $rose(subsys_reset_n_q) && !$past(ptr_load) |->
        (cfg_ptr_q - $past(cfg_ptr_q)) == 4'h1)
        else $error("pointer did not step");
    a_ptr_forced: assert property (
        ptr_load |=> cfg_ptr_q == $past(ptr_value))
        else $error("pointer not loaded");
    c_run: cover property ($fell(subsys_reset_n_q));
    c_side_b: cover property ($fell(subsys_reset_n_q) && req_b_q != 0);
    c_load: cover property (ptr_load);
endmodule // wvr_seq_monitor
bind wvr_sequencer wvr_seq_monitor #(.TMO_BASE(TMO_BASE),
    .STEP_CYC(STEP_CYC)) i_mon (.clk, .rst_n, .liveness_pulse,
    .ptr_load, .ptr_value, .subsys_reset_n_q, .req_a_q, .req_b_q,
    .cmd_strobe_q, .cfg_ptr_q);
`default_nettype wire

// ===== dv/wvr_pm_model.sv
`timescale 1ns/1ns
`default_nettype none
module wvr_pm_model #(
    parameter integer PERIOD = 25
) (
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic en, // processor healthy
    output var logic liveness_pulse // re-arm pulse
);
    int cnt_q = 0;
    initial liveness_pulse = 1'b0;
    always @(negedge clk)
    begin
        cnt_q <= (!rst_n || !en || cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
        liveness_pulse <= rst_n && en && cnt_q == PERIOD - 1;
    end
endmodule // wvr_pm_model
`default_nettype wire

// ===== dv/watchdog_voted_reconfig_sequencer_bench.sv
`timescale 1ns/1ns
`default_nettype none
module watchdog_voted_reconfig_sequencer_bench;
    logic clk = 1'b0, rst_n = 1'b0, pm_en = 1'b0, ptr_load = 1'b0;
    logic [3:0] ptr_value = 4'h0;
    wire live, srst_n, strobe, seq_b;
    wire [3:0] req_a, req_b, ptr;
    wire [14:0] cmd;
    logic [14:0] cmd_1 = 15'h0000;
    int n_errors = 0, n_checks = 0, cyc = 0, k, n;
    always #50 clk = ~clk;
    wvr_pm_model i_pm (.clk(clk), .rst_n(rst_n), .en(pm_en),
        .liveness_pulse(live));
    wvr_sequencer #(.TMO_BASE(50), .TMO_STEP(10), .STEP_CYC(4)) i_dut (
        .clk(clk), .rst_n(rst_n), .liveness_pulse(live),
        .ptr_load(ptr_load), .ptr_value(ptr_value),
        .subsys_reset_n_q(srst_n), .req_a_q(req_a), .req_b_q(req_b),
        .high_power_command_q(cmd), .cmd_strobe_q(strobe),
        .active_seq_b_q(seq_b), .cfg_ptr_q(ptr));
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask
    task wait_run(input logic lvl, input int lim);
        n = 0;
        for (k = 0; k < lim && srst_n !== lvl; k++)
        begin
            @(negedge clk);
            n += (strobe === 1'b1);
        end
        // a level that never comes is a mismatch
        if (srst_n !== lvl)
        begin
            $display("mismatch wait srst_n expected %h seen %h", lvl, srst_n);
            n_errors++;
        end
    endtask
    task t_alive;
        pm_en = 1'b1;
        repeat (300) @(negedge clk);
        chk("req_a", 16'h0, req_a);
        chk("srst_n", 16'h1, srst_n);
        $display("test alive done");
    endtask
    task t_first_run;
        @(posedge clk iff live === 1'b1);
        @(negedge clk) pm_en = 1'b0;
        repeat (56) @(posedge clk);
        @(negedge clk);
        chk("single req", 16'h1, req_a);
        chk("no start", 16'h1, srst_n);
        wait_run(1'b0, 100);
        chk("srst_n", 16'h0, srst_n);
        chk("req_a pair", 16'h3, req_a);
        chk("req_b", 16'h0, req_b);
        chk("seq_b", 16'h0, seq_b);
        wait_run(1'b1, 200);
        chk("strobes", 16'hF, n);
        chk("run short", 16'h1, k <= 16'h40);
        chk("req_a", 16'h0, req_a);
        chk("ptr", 16'h1, ptr);
        cmd_1 = cmd;
        $display("test first run done");
    endtask
    task t_second_run;
        wait_run(1'b0, 3000);
        chk("srst_n", 16'h0, srst_n);
        chk("req_a", 16'h0, req_a);
        chk("req_b", 16'h3, req_b);
        chk("seq_b", 16'h1, seq_b);
        wait_run(1'b1, 200);
        pm_en = 1'b1;
        chk("ptr", 16'h2, ptr);
        chk("cmd differs", 16'h1, cmd !== cmd_1);
        $display("test second run done");
    endtask
    task t_force;
        @(negedge clk);
        ptr_value = 4'hC;
        ptr_load = 1'b1;
        @(negedge clk) ptr_load = 1'b0;
        chk("ptr", 16'hC, ptr);
        $display("test force done");
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            stop_test;
        end
    end
    initial
    begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        chk("ptr reset", 16'h0, ptr);
        t_alive;
        t_first_run;
        t_second_run;
        t_force;
        stop_test;
    end
endmodule // watchdog_voted_reconfig_sequencer_bench
`default_nettype wire
